//--- core/serial_comm_pkg.sv
// Constants shared by the serial communication unit.
package serial_comm_pkg;
    localparam int          OVERSAMPLE      = 16;
    localparam int          HALF_BIT        = 8;
    localparam int          DATA_BITS       = 8;
    localparam int          DEFAULT_BAUD_DIV = 16;
    localparam int          FIFO_DEPTH      = 16;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [3:0]  CNT_ZERO        = 4'h0;
    localparam logic [3:0]  CNT_LAST        = 4'hF;
    localparam logic [3:0]  CNT_MID         = 4'h7;

    typedef enum logic [3:0] {
        RX_IDLE   = 4'b0001,
        RX_START  = 4'b0010,
        RX_DATA   = 4'b0100,
        RX_STOP   = 4'b1000
    } rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE   = 3'b001,
        TX_START  = 3'b010,
        TX_SHIFT  = 3'b100
    } tx_state_t;
endpackage : serial_comm_pkg

//--- core/serial_fifo.sv
// Parameterised valid/ready FIFO for transmit bytes.
`timescale 1ns/1ps
`default_nettype none
module serial_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : serial_fifo
`default_nettype wire

//--- core/serial_comm_unit.sv
// Asynchronous serial unit with receive error handling and four interrupt lines.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: Four interrupt sources gated by three enable bits; rx error and rx end share one.
// R02: Each source drives its own request line.
// R03: Receive-error request is OR of overrun, framing and parity flags.
// R04: Priority fixed: rx error, rx end, tx empty, tx end.
// R05: Tx-empty means writable; tx-end means transmission stopped.
// R06: Transmit writes always accepted; early write overwrites pending byte.
// R07: Software checks buffer-empty before writing a new byte.
// R08: Overrun sets overrun flag, keeps rx-full, does not copy shift register.
// R09: Framing/parity without overrun copies byte, sets flags, rx-full stays zero.
// R10: Coincident errors set all matching flags together.
// R11: Line held low gives framing error and zero data byte.
// R12: Reception continues during a break, so errors recur.
// R13: Receive sampling clock runs at sixteen times baud rate.
// R14: Start edge found by sampling on oversampling falling edge.
// R15: Every bit sampled once at its centre on rising edge.
// R16: Any error flag blocks transmit and receive; rx-full stays clear.
// R17: Rx-full with enable requests rx end; overrun requests rx error.
// R18: Byte moved to shift register sets buffer-empty and may request.
// R19: Buffer empty at last data bit sets tx-end and may request.
// R20: Requests are levels: flag and enable both one.
module serial_comm_unit #(
    parameter int BAUD_DIV   = serial_comm_pkg::DEFAULT_BAUD_DIV,
    parameter int FIFO_DEPTH = serial_comm_pkg::FIFO_DEPTH
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       rx_pin,
    output logic            tx_pin,
    input  wire logic       tx_enable,
    input  wire logic       rx_enable,
    input  wire logic       parity_en,
    input  wire logic       parity_odd,
    input  wire logic       tx_empty_irq_en,
    input  wire logic       rx_irq_en,
    input  wire logic       tx_end_irq_en,
    input  wire logic       tx_write,
    input  wire logic [7:0] tx_wdata,
    input  wire logic       rx_read,
    input  wire logic       rx_full_clr,
    input  wire logic       overrun_clr,
    input  wire logic       framing_clr,
    input  wire logic       parity_clr,
    output logic            tx_buf_empty_flag,
    output logic            tx_end_flag,
    output logic            rx_full_flag,
    output logic            overrun_flag,
    output logic            framing_err_flag,
    output logic            parity_err_flag,
    output logic [7:0]      rx_data_reg,
    output logic            rx_error_irq,
    output logic            rx_full_irq,
    output logic            tx_empty_irq,
    output logic            tx_end_irq,
    output logic [1:0]      irq_top_id,
    output logic            irq_any
);
    logic                     rx_s1_q;
    logic                     rx_s2_q;
    logic [15:0]              div_q;
    logic                     os_rise;
    logic                     os_fall;
    serial_comm_pkg::rx_state_t rx_st_q;
    logic [3:0]               rx_ph_q;
    logic [3:0]               rx_bit_q;
    logic [7:0]               rx_shift_reg;
    logic                     rx_par_q;
    logic                     frame_done;
    logic                     stop_bad;
    logic                     par_bad;
    logic                     err_any;
    serial_comm_pkg::tx_state_t tx_st_q;
    logic [3:0]               tx_ph_q;
    logic [3:0]               tx_bit_q;
    logic [7:0]               tx_shift_reg;
    logic                     tx_par_q;
    logic                     tx_load;
    logic                     fifo_valid;
    logic [7:0]               fifo_data;
    logic [7:0]               tx_data_reg;
    logic                     bit_tick;

    // Oversampling clock: low half then high half of each sixteenth bit.
    // R13: sixteen ticks per bit
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= (div_q == 16'(BAUD_DIV / serial_comm_pkg::OVERSAMPLE - 1)) ? '0 : div_q + 1'b1;
        end
    end
    assign os_rise = (div_q == 16'(BAUD_DIV / serial_comm_pkg::OVERSAMPLE - 1));
    assign os_fall = (div_q == '0);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
        end
    end

    // R16: errors freeze both directions
    assign err_any = overrun_flag | framing_err_flag | parity_err_flag;

    // Transmit byte buffer; its ready is not exposed because writes always land.
    serial_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (tx_write),
        .in_ready  (),
        .in_data   (tx_wdata),
        .out_valid (fifo_valid),
        .out_ready (tx_load),
        .out_data  (fifo_data)
    );

    // R06: latest write overwrites the pending byte
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_data_reg <= serial_comm_pkg::BYTE_ZERO;
        end
        else if (fifo_valid)
        begin
            tx_data_reg <= fifo_data;
        end
    end

    assign tx_load  = fifo_valid;
    assign bit_tick = os_rise && (tx_ph_q == serial_comm_pkg::CNT_LAST);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_st_q      <= serial_comm_pkg::TX_IDLE;
            tx_ph_q      <= serial_comm_pkg::CNT_ZERO;
            tx_bit_q     <= serial_comm_pkg::CNT_ZERO;
            tx_shift_reg <= serial_comm_pkg::BYTE_ZERO;
            tx_par_q     <= 1'b0;
            tx_pin       <= 1'b1;
        end
        else
        begin
            if (os_rise)
            begin
                tx_ph_q <= tx_ph_q + 1'b1;
            end
            unique case (tx_st_q)
                serial_comm_pkg::TX_IDLE:
                begin
                    tx_pin <= 1'b1;
                    if (tx_enable && !err_any && !tx_buf_empty_flag && bit_tick)
                    begin
                        tx_shift_reg <= tx_data_reg;
                        tx_par_q     <= parity_odd;
                        tx_st_q      <= serial_comm_pkg::TX_START;
                        tx_pin       <= 1'b0;
                    end
                end
                serial_comm_pkg::TX_START:
                begin
                    if (bit_tick)
                    begin
                        tx_pin   <= tx_shift_reg[0];
                        tx_par_q <= tx_par_q ^ tx_shift_reg[0];
                        tx_bit_q <= 4'(serial_comm_pkg::DATA_BITS);
                        tx_st_q  <= serial_comm_pkg::TX_SHIFT;
                    end
                end
                serial_comm_pkg::TX_SHIFT:
                begin
                    if (bit_tick)
                    begin
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bit_q     <= tx_bit_q - 1'b1;
                        if (tx_bit_q > 4'h1)
                        begin
                            tx_pin   <= tx_shift_reg[1];
                            tx_par_q <= tx_par_q ^ tx_shift_reg[1];
                        end
                        else if (tx_bit_q == 4'h1 && parity_en)
                        begin
                            tx_pin <= tx_par_q;
                        end
                        else
                        begin
                            tx_pin  <= 1'b1;
                            tx_st_q <= serial_comm_pkg::TX_IDLE;
                        end
                    end
                end
                default:
                begin
                    tx_st_q <= serial_comm_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // R18: buffer-empty set when the byte reaches the shift register
    // R06: a new byte clears it without any check
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_buf_empty_flag <= 1'b1;
        end
        else if (tx_st_q == serial_comm_pkg::TX_IDLE && tx_enable && !err_any
                 && !tx_buf_empty_flag && bit_tick)
        begin
            tx_buf_empty_flag <= 1'b1;
        end
        else if (fifo_valid)
        begin
            tx_buf_empty_flag <= 1'b0;
        end
    end

    // R19: tx-end set at last bit when nothing is waiting
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_end_flag <= 1'b1;
        end
        else if (tx_st_q == serial_comm_pkg::TX_SHIFT && bit_tick
                 && tx_bit_q == 4'h1 && tx_buf_empty_flag)
        begin
            tx_end_flag <= 1'b1;
        end
        else if (tx_st_q == serial_comm_pkg::TX_START)
        begin
            tx_end_flag <= 1'b0;
        end
    end

    // R14: start edge checked on oversampling falling edge
    // R15: bits sampled at phase seven on rising edge
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_st_q      <= serial_comm_pkg::RX_IDLE;
            rx_ph_q      <= serial_comm_pkg::CNT_ZERO;
            rx_bit_q     <= serial_comm_pkg::CNT_ZERO;
            rx_shift_reg <= serial_comm_pkg::BYTE_ZERO;
            rx_par_q     <= 1'b0;
        end
        else
        begin
            if (os_rise)
            begin
                rx_ph_q <= rx_ph_q + 1'b1;
            end
            unique case (rx_st_q)
                serial_comm_pkg::RX_IDLE:
                begin
                    // R12: receiver keeps running through a break
                    if (rx_enable && !err_any && os_fall && !rx_s2_q)
                    begin
                        rx_ph_q <= serial_comm_pkg::CNT_ZERO;
                        rx_st_q <= serial_comm_pkg::RX_START;
                    end
                end
                serial_comm_pkg::RX_START:
                begin
                    if (os_rise && rx_ph_q == serial_comm_pkg::CNT_MID)
                    begin
                        rx_st_q  <= rx_s2_q ? serial_comm_pkg::RX_IDLE
                                            : serial_comm_pkg::RX_DATA;
                        rx_bit_q <= 4'(serial_comm_pkg::DATA_BITS);
                        rx_par_q <= parity_odd;
                    end
                end
                serial_comm_pkg::RX_DATA:
                begin
                    if (os_rise && rx_ph_q == serial_comm_pkg::CNT_MID)
                    begin
                        rx_bit_q <= rx_bit_q - 1'b1;
                        rx_par_q <= rx_par_q ^ rx_s2_q;
                        if (rx_bit_q != 4'h0)
                        begin
                            rx_shift_reg <= {rx_s2_q, rx_shift_reg[7:1]};
                        end
                        if (rx_bit_q == 4'h1 && !parity_en || rx_bit_q == 4'h0)
                        begin
                            rx_st_q <= serial_comm_pkg::RX_STOP;
                        end
                    end
                end
                serial_comm_pkg::RX_STOP:
                begin
                    if (os_rise && rx_ph_q == serial_comm_pkg::CNT_MID)
                    begin
                        rx_st_q <= serial_comm_pkg::RX_IDLE;
                    end
                end
                default:
                begin
                    rx_st_q <= serial_comm_pkg::RX_IDLE;
                end
            endcase
        end
    end

    assign frame_done = (rx_st_q == serial_comm_pkg::RX_STOP) && os_rise
                        && (rx_ph_q == serial_comm_pkg::CNT_MID);
    // R11: a low stop bit is a framing error
    assign stop_bad   = !rx_s2_q;
    assign par_bad    = parity_en && rx_par_q;

    // R08: overrun keeps the old byte and rx-full
    // R09: other errors still copy the byte
    // R11: break data copied as zero byte
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_data_reg <= serial_comm_pkg::BYTE_ZERO;
        end
        else if (frame_done && !rx_full_flag)
        begin
            rx_data_reg <= rx_shift_reg;
        end
    end

    // R16: rx-full only on a clean frame; set beats clear
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_full_flag <= 1'b0;
        end
        else if (frame_done && !rx_full_flag && !stop_bad && !par_bad)
        begin
            rx_full_flag <= 1'b1;
        end
        else if (rx_full_clr || rx_read)
        begin
            rx_full_flag <= 1'b0;
        end
    end

    // R10: all coincident error flags set together; set beats clear
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overrun_flag     <= 1'b0;
            framing_err_flag <= 1'b0;
            parity_err_flag  <= 1'b0;
        end
        else
        begin
            overrun_flag     <= (frame_done && rx_full_flag) || (overrun_flag && !overrun_clr);
            framing_err_flag <= (frame_done && stop_bad) || (framing_err_flag && !framing_clr);
            parity_err_flag  <= (frame_done && par_bad) || (parity_err_flag && !parity_clr);
        end
    end

    // R20: level requests from flag and enable
    // R01: each source gated by its enable
    // R02: one line per source
    // R03: error request ORs three flags
    // R17: rx end and overrun both use the receive enable
    // R05: tx-empty and tx-end follow their flags
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_error_irq <= 1'b0;
            rx_full_irq  <= 1'b0;
            tx_empty_irq <= 1'b0;
            tx_end_irq   <= 1'b0;
        end
        else
        begin
            rx_error_irq <= rx_irq_en && err_any;
            rx_full_irq  <= rx_irq_en && rx_full_flag;
            tx_empty_irq <= tx_empty_irq_en && tx_buf_empty_flag;
            tx_end_irq   <= tx_end_irq_en && tx_end_flag;
        end
    end

    // R04: highest pending source encoded, 0 is rx error
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_top_id <= 2'h0;
            irq_any    <= 1'b0;
        end
        else
        begin
            irq_any    <= rx_error_irq | rx_full_irq | tx_empty_irq | tx_end_irq;
            irq_top_id <= rx_error_irq ? 2'h0 : rx_full_irq ? 2'h1 : tx_empty_irq ? 2'h2 : 2'h3;
        end
    end
endmodule : serial_comm_unit
`default_nettype wire

//--- dv/serial_comm_unit_props.sv
// Concurrent checks on the serial unit's flags, request lines and transmit framing.
`timescale 1ns/1ps
`default_nettype none
module serial_comm_unit_props #(
    parameter int BAUD_DIV = 16
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       tx_pin,
    input  wire logic       rx_irq_en,
    input  wire logic       tx_empty_irq_en,
    input  wire logic       tx_end_irq_en,
    input  wire logic       tx_buf_empty_flag,
    input  wire logic       tx_end_flag,
    input  wire logic       rx_full_flag,
    input  wire logic       overrun_flag,
    input  wire logic       framing_err_flag,
    input  wire logic       parity_err_flag,
    input  wire logic [7:0] rx_data_reg,
    input  wire logic       rx_error_irq,
    input  wire logic       rx_full_irq,
    input  wire logic       tx_empty_irq,
    input  wire logic       tx_end_irq,
    input  wire logic [1:0] irq_top_id,
    input  wire logic       irq_any
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic any_err = overrun_flag | framing_err_flag | parity_err_flag;
    // A start bit is only recognised as such when the line left the idle state.
    sequence s_idle_start;
        $past(tx_end_flag) && $fell(tx_pin);
    endsequence
    sequence s_start_low;
        (!tx_pin && !tx_end_flag) [*8];
    endsequence
    a_err_irq_or: assert property (rx_error_irq == $past(any_err && rx_irq_en))
        else $error("receive error request mismatch");
    a_full_irq_lvl: assert property (rx_full_irq == $past(rx_full_flag && rx_irq_en))
        else $error("receive full request mismatch");
    a_txe_irq_lvl: assert property ($past(rst_n) |-> tx_empty_irq == $past(tx_buf_empty_flag && tx_empty_irq_en))
        else $error("transmit empty request mismatch");
    a_tx_end_flag_irq_lvl: assert property ($past(rst_n) |-> tx_end_irq == $past(tx_end_flag && tx_end_irq_en))
        else $error("transmit end request mismatch");
    a_any_irq_or: assert property (irq_any == $past(rx_error_irq || rx_full_irq || tx_empty_irq || tx_end_irq))
        else $error("summary request mismatch");
    a_prio_order: assert property (irq_any |-> irq_top_id == ($past(rx_error_irq) ? 2'h0 : $past(rx_full_irq) ? 2'h1 : $past(tx_empty_irq) ? 2'h2 : 2'h3))
        else $error("request priority wrong");
    a_ovr_keeps_data: assert property ($rose(overrun_flag) |-> $stable(rx_data_reg) && rx_full_flag)
        else $error("overrun disturbed receive data");
    a_fer_no_full: assert property (($rose(framing_err_flag) || $rose(parity_err_flag)) && !overrun_flag |-> !rx_full_flag)
        else $error("receive full set with error");
    a_err_blocks_rx: assert property (any_err |=> !$rose(rx_full_flag))
        else $error("receive completed while error flag set");
    a_tx_start_bit: assert property (s_idle_start |-> ##1 s_start_low)
        else $error("start bit or end flag wrong");
endmodule : serial_comm_unit_props
bind serial_comm_unit serial_comm_unit_props #(.BAUD_DIV(BAUD_DIV)) chk_i (.*);
`default_nettype wire

//--- dv/serial_partner.sv
// Remote serial station: frames bytes onto the receive pin and decodes the transmit pin.
`timescale 1ns/1ps
`default_nettype none
module serial_partner #(
    parameter int BIT_CYC = 16
) (
    input  wire logic       core_clk,
    output logic            line_out,
    input  wire logic       line_in,
    output logic [7:0]      got_byte,
    output logic            got_stb
);
    initial line_out = 1'b1;
    initial got_stb = 1'b0;
    initial got_byte = 8'h00;
    task automatic hold(input logic b);
        line_out <= b;
        repeat (BIT_CYC) @(posedge core_clk);
    endtask : hold
    task automatic send(input logic [7:0] d, input logic par_on, input logic par_b,
                        input logic stop);
        hold(1'b0);
        for (int i = 0; i < 8; i++)
            hold(d[i]);
        if (par_on)
            hold(par_b);
        hold(stop);
        line_out <= 1'b1;
    endtask : send
    // falling edge starts a frame, bits taken mid-bit
    always
    begin : rx_decode
        logic [7:0] r;
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC) @(posedge core_clk);
            r[i] = line_in;
        end
        repeat (BIT_CYC) @(posedge core_clk);
        got_byte <= r;
        got_stb <= 1'b1;
        @(posedge core_clk);
        got_stb <= 1'b0;
    end
endmodule : serial_partner
`default_nettype wire

//--- dv/serial_comm_unit_tb.sv
// Self-checking bench for the serial unit and a remote station.
`timescale 1ns/1ps
`default_nettype none
module serial_comm_unit_tb;
    localparam int BD = 16;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       tx_enable = 1'b1, rx_enable = 1'b1, parity_en = 1'b0, parity_odd = 1'b0;
    logic       tx_empty_irq_en = 1'b1, rx_irq_en = 1'b1, tx_end_irq_en = 1'b1;
    logic       tx_write = 1'b0, rx_read = 1'b0, rx_full_clr = 1'b0;
    logic       overrun_clr = 1'b0, framing_clr = 1'b0, parity_clr = 1'b0;
    logic [7:0] tx_wdata = 8'h00;
    logic       rx_pin, tx_pin, tx_buf_empty_flag, tx_end_flag, rx_full_flag, overrun_flag;
    logic       framing_err_flag, parity_err_flag, rx_error_irq, rx_full_irq, tx_empty_irq;
    logic       tx_end_irq, irq_any, got_stb;
    logic [1:0] irq_top_id;
    logic [7:0] rx_data_reg, got_byte, d;
    logic [7:0] expq[$];
    int         seed = 82, n_fail = 0, n_compared = 0;
    always #2 core_clk = ~core_clk;
    serial_comm_unit #(.BAUD_DIV(BD)) uut (.*);
    serial_partner #(.BIT_CYC(BD)) peer (
        .core_clk(core_clk), .line_out(rx_pin), .line_in(tx_pin),
        .got_byte(got_byte), .got_stb(got_stb));
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] flg();
        return {2'b00, tx_buf_empty_flag, tx_end_flag, rx_full_flag, overrun_flag,
                framing_err_flag, parity_err_flag};
    endfunction : flg
    function automatic logic [7:0] irqs();
        return {1'b0, irq_any, irq_top_id, rx_error_irq, rx_full_irq, tx_empty_irq, tx_end_irq};
    endfunction : irqs
    task automatic clr(input logic [4:0] m);
        {rx_read, rx_full_clr, overrun_clr, framing_clr, parity_clr} <= m;
        cyc(1);
        {rx_read, rx_full_clr, overrun_clr, framing_clr, parity_clr} <= 5'h00;
        cyc(3);
    endtask : clr
    task automatic results();
        $display("compared=%0d mismatches=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    always @(posedge core_clk)
        if (got_stb === 1'b1)
            chk(got_byte, expq.pop_front());
    // Budget is over ten times the run of about 2600 cycles.
    initial
    begin
        cyc(30000);
        n_fail++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        results();
    end
    initial
    begin
        cyc(20);
        rst_n <= 1'b1;
        cyc(4);
        chk(flg(), 8'h30);
        chk(irqs(), 8'h63);
        tx_empty_irq_en <= 1'b0;
        cyc(4);
        chk(irqs(), 8'h71);
        $display("test reset done");
        d = 8'($random(seed));
        peer.send(d, 1'b0, 1'b0, 1'b1);
        cyc(4);
        chk(flg(), 8'h38);
        chk(rx_data_reg, d);
        chk(irqs(), 8'h55);
        peer.send(8'($random(seed)), 1'b0, 1'b0, 1'b1);
        cyc(4);
        chk(flg(), 8'h3C);
        chk(rx_data_reg, d);
        chk(irqs(), 8'h4D);
        clr(5'h04);
        chk(flg(), 8'h38);
        peer.send(8'($random(seed)), 1'b0, 1'b0, 1'b0);
        cyc(4);
        chk(flg(), 8'h3E);
        chk(rx_data_reg, d);
        clr(5'h17);
        chk(flg(), 8'h30);
        $display("test overrun done");
        parity_en <= 1'b1;
        for (int k = 1; k < 4; k++)
        begin
            d = 8'($random(seed));
            peer.send(d, 1'b1, (^d) ^ k[0], !k[1]);
            cyc(4);
            chk(flg(), 8'h30 | 8'(k));
            chk(rx_data_reg, d);
            clr(5'h1F);
        end
        parity_odd <= 1'b1;
        d = 8'($random(seed));
        peer.send(d, 1'b1, ~^d, 1'b0);
        cyc(4);
        peer.send(8'($random(seed)), 1'b1, 1'b0, 1'b1);
        cyc(4);
        chk(flg(), 8'h32);
        chk(rx_data_reg, d);
        clr(5'h1F);
        $display("test parity done");
        parity_en <= 1'b0;
        repeat (12) peer.hold(1'b0);
        chk(flg(), 8'h32);
        chk(rx_data_reg, 8'h00);
        clr(5'h1F);
        repeat (12) peer.hold(1'b0);
        chk(flg(), 8'h32);
        repeat (2) peer.hold(1'b1);
        clr(5'h1F);
        chk(flg(), 8'h30);
        $display("test break done");
        tx_empty_irq_en <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            // write only into a free buffer
            for (int w = 0; w < 400 && tx_buf_empty_flag !== 1'b1; w++) cyc(1);
            d = 8'($random(seed));
            expq.push_back(d);
            tx_wdata <= d;
            tx_write <= 1'b1;
            cyc(1);
            tx_write <= 1'b0;
            cyc(3);
        end
        for (int w = 0; w < 2000 && !(tx_end_flag === 1'b1 && expq.size() == 0); w++) cyc(1);
        cyc(BD);
        chk(8'(expq.size()), 8'h00);
        chk(flg(), 8'h30);
        chk(irqs(), 8'h63);
        $display("test transmit done");
        tx_enable <= 1'b0;
        tx_empty_irq_en <= 1'b0;
        tx_wdata <= 8'($random(seed));
        tx_write <= 1'b1;
        cyc(1);
        d = 8'($random(seed));
        tx_wdata <= d;
        cyc(1);
        tx_write <= 1'b0;
        cyc(4);
        chk(flg(), 8'h10);
        chk(irqs(), 8'h71);
        expq.push_back(d);
        tx_enable <= 1'b1;
        for (int w = 0; w < 800 && !(tx_end_flag === 1'b1 && expq.size() == 0); w++) cyc(1);
        cyc(BD);
        chk(8'(expq.size()), 8'h00);
        chk(flg(), 8'h30);
        $display("test overwrite done");
        results();
    end
endmodule : serial_comm_unit_tb
`default_nettype wire
